//--- src/fsw_pkg.sv
// fsw_pkg: constants, field layout and states of the flash status block
// assumes: shared by the status block and its non-volatile store
package fsw_pkg;
    // instruction codes
    localparam logic [7:0] OPC_WREN = 8'h06;
    localparam logic [7:0] OPC_WRDI = 8'h04;
    localparam logic [7:0] OPC_RDSR_LO = 8'h05;
    localparam logic [7:0] OPC_RDSR_HI = 8'h35;
    localparam logic [7:0] OPC_WRSR = 8'h01;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_SECT_ERASE = 8'h20;
    localparam logic [7:0] OPC_HBLK_ERASE = 8'h52;
    localparam logic [7:0] OPC_BLK_ERASE = 8'hd8;
    localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
    localparam logic [7:0] OPC_SEC_PROG = 8'h42;
    localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7a;
    localparam logic [7:0] OPC_DEEP_PD = 8'hb9;
    localparam logic [7:0] OPC_RELEASE = 8'hab;
    localparam logic [7:0] OPC_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OPC_QUAD_IO = 8'heb;
    // lower status byte fields
    localparam int LO_GUARD = 7;
    localparam int LO_SMALL = 6;
    localparam int LO_LOWEND = 5;
    localparam int LO_RANGE_HI = 4;
    localparam int LO_RANGE_LO = 2;
    localparam int LO_WEL = 1;
    localparam int LO_BUSY = 0;
    // upper status byte fields
    localparam int HI_PAUSED = 7;
    localparam int HI_INVERT = 6;
    localparam int HI_LOCK_3 = 5;
    localparam int HI_LOCK_2 = 4;
    localparam int HI_LOCK_1 = 3;
    localparam int HI_QUAD = 1;
    localparam int HI_GUARD = 0;
    // reset values and masks
    localparam logic [7:0] LO_RESET = 8'h00;
    localparam logic [7:0] HI_RESET = 8'h00;
    localparam logic [7:0] LO_WR_MASK = 8'hfc;
    localparam logic [7:0] HI_WR_MASK = 8'h7b;
    localparam logic [7:0] HI_LOCK_MASK = 8'h38;
    // non-volatile word addresses
    localparam logic NV_ADDR_LO = 1'b0;
    localparam logic NV_ADDR_HI = 1'b1;
    // sampled pin positions
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_WP = 3;
    localparam int PIN_HOLD = 4;
    localparam int PIN_N = 5;
    // busy durations in reference clock cycles
    localparam int unsigned OP_CYCLES_DEF = 2000;
    localparam int unsigned WRSR_CYCLES_DEF = 500;
    localparam int ADDR_W = 21;
    typedef enum logic [2:0] {
        ST_LOAD0, ST_LOAD1, ST_LOAD2, ST_IDLE,
        ST_SAVE_LO, ST_SAVE_HI, ST_BUSY, ST_SUSP
    } fsw_state_t;
endpackage : fsw_pkg

//--- src/fsw_nv_if.sv
// fsw_nv_if: port bundle between status block and non-volatile store
// assumes: one writer/reader, read data registered in the store
`timescale 1ns/1ps
interface fsw_nv_if #(parameter int WIDTH = 8);
    logic we;
    logic addr;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface : fsw_nv_if

//--- src/fsw_nv_store.sv
// fsw_nv_store: non-volatile status words, survive the power-on reset
// assumes: only the factory reset returns the words to their defaults
`timescale 1ns/1ps
module fsw_nv_store
    import fsw_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_factory_nrst,
    fsw_nv_if.store nv
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // store is addressed by a single bit
    if (DEPTH != 2) begin : g_bad_depth
        $error("fsw_nv_store: DEPTH must be 2");
    end

    // cells, erased only by the factory reset
    for (genvar g = 0; g < DEPTH; g++) begin : g_cell
        always_ff @(posedge i_clk or negedge i_factory_nrst) begin
            if (!i_factory_nrst) begin
                mem_q[g] <= '0;
            end else if (nv.we && (nv.addr == 1'(g))) begin
                mem_q[g] <= nv.wdata;
            end
        end
    end

    // registered read port
    always_ff @(posedge i_clk or negedge i_factory_nrst) begin
        if (!i_factory_nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[nv.addr];
        end
    end

    assign nv.rdata = rdata_q;
endmodule : fsw_nv_store

//--- src/fsw_status_protect.sv
// fsw_status_protect: flash status bytes and write protection logic
// assumes: serial pins are asynchronous, sampled by I_REF_CLK (100 MHz)
// How it works
// [R1] suspend sets paused flag, resume or power cycle clears it
// [R2] invert bit swaps protected and unprotected areas
// [R3] three one-time lock bits, each locks its security register forever
// [R4] four-lane enable disables guard and pause pin functions
// [R5] host never sets four-lane enable with guard pins tied
// [R6] guard 00: status write allowed once write permit is set
// [R7] guard 01 with guard pin low: status writes refused
// [R8] guard 01 with guard pin high: writes allowed with write permit
// [R9] guard 10: writes refused until power cycle, which clears guard
// [R10] guard 11: status writes refused permanently
// [R11] busy flag high during program, erase or status write
// [R12] write permit shown; when clear, writes, program, erase refused
// [R13] host sets write permit before every modifying instruction
// [R14] small unit select: 64KB blocks or 4KB sectors
// [R15] low end bit: protect from top down or bottom up
// [R16] range select sizes protected area; program/erase inside refused
// [R17] range bits written only while hardware protection not in force
// [R18] in deep power-down only the release instruction is obeyed
// [R19] guard bits kept non-volatile, readable and writable
// [R20] quad reads executed only with four-lane enable set
// [R21] modifying instructions need select raised on a byte boundary
// [R22] power-on clears busy, permit, paused; reloads non-volatile bits
// [R23] host writes to busy, permit, paused, reserved bits ignored
`timescale 1ns/1ps
module fsw_status_protect
    import fsw_pkg::*;
#(
    parameter int unsigned OP_CYCLES = OP_CYCLES_DEF,
    parameter int unsigned WRSR_CYCLES = WRSR_CYCLES_DEF
) (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_FACTORY_NRST,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_SI,
    input wire logic I_WP_N,
    input wire logic I_HOLD_N,
    output logic O_SO,
    output logic O_SO_OE,
    output logic [7:0] O_STATUS_LO,
    output logic [7:0] O_STATUS_HI,
    output logic O_QUAD_LANES,
    output logic O_QUAD_READ,
    output logic O_CMD_REJECT,
    output logic O_DEEP_PD
);
    // busy counts must be at least one cycle
    if (OP_CYCLES < 1 || WRSR_CYCLES < 1) begin : g_bad_cycles
        $error("fsw_status_protect: busy counts must be >= 1");
    end

    fsw_nv_if #(.WIDTH(8)) nv ();

    fsw_nv_store #(.WIDTH(8), .DEPTH(2)) u_nv (
        .i_clk(I_REF_CLK),
        .i_factory_nrst(I_FACTORY_NRST),
        .nv(nv)
    );

    // address inside the protected area
    function automatic logic in_prot(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
        logic [2:0] bp;
        logic [5:0] cnt;
        logic [9:0] cnt4;
        logic [2:0] k;
        logic hit;
        bp = lo[LO_RANGE_HI:LO_RANGE_LO];
        k = bp[2] ? 3'd4 : bp;
        cnt = 6'd1 << (bp - 3'd1);
        cnt4 = 10'd1 << (k - 3'd1);
        if (bp == 3'b000) begin
            hit = 1'b0;
        end else if (bp[2:1] == 2'b11) begin
            hit = 1'b1;
        end else if (!lo[LO_SMALL]) begin
            hit = lo[LO_LOWEND] ? ({1'b0, a[20:16]} < cnt)
                                : ({1'b0, a[20:16]} >= 6'd32 - cnt);
        end else begin
            hit = lo[LO_LOWEND] ? ({1'b0, a[20:12]} < cnt4)
                                : ({1'b0, a[20:12]} >= 10'd512 - cnt4);
        end
        return hit ^ hi[HI_INVERT]; // [R2] [R14] [R15] [R16]
    endfunction : in_prot

    // pin synchronisers: first stage feeds only the second
    logic [PIN_N-1:0] pin_m_q;
    logic [PIN_N-1:0] pin_s_q;
    logic [PIN_N-1:0] pin_d_q;
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pin_m_q <= 5'h1a;
            pin_s_q <= 5'h1a;
            pin_d_q <= 5'h1a;
        end else begin
            pin_m_q <= {I_HOLD_N, I_WP_N, I_SI, I_CS_N, I_SCLK};
            pin_s_q <= pin_m_q;
            pin_d_q <= pin_s_q;
        end
    end

    fsw_state_t state_q;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic [31:0] tmr_q;
    logic op_pe_q;
    logic dpd_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] nbytes_q;
    logic [7:0] sh_in_q;
    logic [7:0] opc_q;
    logic [7:0] d1_q;
    logic [7:0] d2_q;
    logic [23:0] addr_q;
    logic [7:0] sh_out_q;
    logic rd_act_q;

    // pin events; four-lane mode turns guard and pause pins into data
    wire cs_sel = !pin_s_q[PIN_CS];
    wire quad_on = hi_q[HI_QUAD];
    wire hold_act = cs_sel && !quad_on && !pin_s_q[PIN_HOLD]; // [R4]
    wire wp_high = quad_on || pin_s_q[PIN_WP]; // [R4]
    wire clk_ok = cs_sel && !hold_act;
    wire rise = clk_ok && pin_s_q[PIN_SCLK] && !pin_d_q[PIN_SCLK];
    wire fall = clk_ok && !pin_s_q[PIN_SCLK] && pin_d_q[PIN_SCLK];
    wire cs_fall = pin_d_q[PIN_CS] && !pin_s_q[PIN_CS];
    wire cs_rise = !pin_d_q[PIN_CS] && pin_s_q[PIN_CS];
    wire byte_done = rise && (bit_cnt_q == 3'd7);
    wire [7:0] byte_in = {sh_in_q[6:0], pin_s_q[PIN_SI]};
    wire opc_done = byte_done && (nbytes_q == 3'd0);
    wire [7:0] cur_opc = (nbytes_q == 3'd0) ? byte_in : opc_q;

    // frame capture: bit and byte counters, opcode, data, address
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            bit_cnt_q <= 3'd0;
            nbytes_q <= 3'd0;
            sh_in_q <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_q <= 3'd0;
            nbytes_q <= 3'd0;
        end else if (rise) begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            sh_in_q <= byte_in;
            if (byte_done && nbytes_q != 3'd7) begin
                nbytes_q <= nbytes_q + 3'd1;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            opc_q <= 8'h00;
            d1_q <= 8'h00;
            d2_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (byte_done) begin
            if (nbytes_q == 3'd0) opc_q <= byte_in;
            if (nbytes_q == 3'd1) d1_q <= byte_in;
            if (nbytes_q == 3'd2) d2_q <= byte_in;
            if (nbytes_q != 3'd0 && nbytes_q < 3'd4) begin
                addr_q <= {addr_q[15:0], byte_in};
            end
        end
    end

    // instruction decode, valid at the rising select edge
    wire [ADDR_W-1:0] a = addr_q[ADDR_W-1:0];
    wire [2:0] bp = lo_q[LO_RANGE_HI:LO_RANGE_LO];
    wire [1:0] guard = {hi_q[HI_GUARD], lo_q[LO_GUARD]};
    wire full = (bit_cnt_q == 3'd0) && (nbytes_q != 3'd0); // [R21]
    wire ex = cs_rise && full && (!dpd_q || opc_q == OPC_RELEASE); // [R18]
    wire idle = (state_q == ST_IDLE);
    wire write_permit_latch = lo_q[LO_WEL];
    wire is_erase = (opc_q == OPC_SECT_ERASE) || (opc_q == OPC_BLK_ERASE)
                 || (opc_q == OPC_HBLK_ERASE) || (opc_q == OPC_SEC_ERASE);
    wire is_addr_op = is_erase || (opc_q == OPC_PROG)
                   || (opc_q == OPC_SEC_PROG);
    wire is_pe = is_addr_op || (opc_q == OPC_CHIP_ERASE);
    wire is_wr = is_pe || (opc_q == OPC_WRSR) || (opc_q == OPC_WREN)
              || (opc_q == OPC_WRDI) || (opc_q == OPC_DEEP_PD);

    // end of the erased unit, so a partly covered unit is refused
    wire [ADDR_W-1:0] a_end =
        (opc_q == OPC_BLK_ERASE) ? (a | 21'h00ffff) :
        (opc_q == OPC_HBLK_ERASE) ? (a | 21'h007fff) :
        (opc_q == OPC_SECT_ERASE) ? (a | 21'h000fff) : a;
    wire prot_none = hi_q[HI_INVERT] ? (bp[2:1] == 2'b11) : (bp == 3'b000);
    wire sec_lock = (a[13:12] == 2'd1) ? hi_q[HI_LOCK_1] :
                    (a[13:12] == 2'd2) ? hi_q[HI_LOCK_2] :
                    (a[13:12] == 2'd3) ? hi_q[HI_LOCK_3] : 1'b1; // [R3]
    wire sec_op = (opc_q == OPC_SEC_PROG) || (opc_q == OPC_SEC_ERASE);
    wire blocked = (opc_q == OPC_CHIP_ERASE) ? !prot_none :
                   sec_op ? sec_lock :
                   (in_prot(a, lo_q, hi_q) || in_prot(a_end, lo_q, hi_q));

    // guard modes for status register writes
    wire guard_open = (guard == 2'b00) || ((guard == 2'b01) && wp_high); // [R6] [R7] [R8] [R9] [R10] [R17]
    wire wrsr_go = ex && (opc_q == OPC_WRSR) && (nbytes_q >= 3'd2)
                && idle && write_permit_latch && guard_open; // [R12]
    wire pe_go = ex && is_pe && idle && write_permit_latch && !blocked
              && (!is_addr_op || nbytes_q >= 3'd4); // [R12] [R16]
    wire wren_go = ex && (opc_q == OPC_WREN)
                && (idle || state_q == ST_SUSP);
    wire wrdi_go = ex && (opc_q == OPC_WRDI)
                && (idle || state_q == ST_SUSP);
    wire dpd_go = ex && (opc_q == OPC_DEEP_PD) && idle;
    wire rel_go = ex && (opc_q == OPC_RELEASE);
    wire susp_go = ex && (opc_q == OPC_SUSPEND)
                && (state_q == ST_BUSY) && op_pe_q;
    wire resume_go = ex && (opc_q == OPC_RESUME) && (state_q == ST_SUSP);
    wire wr_taken = wrsr_go || pe_go || wren_go || wrdi_go || dpd_go;
    wire quad_op = (byte_in == OPC_QUAD_OUT) || (byte_in == OPC_QUAD_IO);
    wire quad_go = opc_done && quad_op && !dpd_q && quad_on; // [R20]
    wire reject = (cs_rise && nbytes_q != 3'd0 && is_wr && !wr_taken)
               || (opc_done && quad_op && !quad_go); // [R21]

    // new status values; host cannot touch busy, permit, paused, reserved
    wire [7:0] new_lo = (lo_q & ~LO_WR_MASK) | (d1_q & LO_WR_MASK); // [R23]
    wire [7:0] new_hi = (hi_q & ~HI_WR_MASK) | (d2_q & HI_WR_MASK)
                      | (hi_q & HI_LOCK_MASK); // [R3] [R23]
    // power cycle ends the supply lock-down mode
    wire lockdown = nv.rdata[HI_GUARD] && !lo_q[LO_GUARD];
    wire [7:0] load_hi = nv.rdata & HI_WR_MASK
                       & ~(lockdown ? 8'h01 : 8'h00); // [R9] [R22]

    // non-volatile store access
    assign nv.we = (state_q == ST_SAVE_LO) || (state_q == ST_SAVE_HI);
    assign nv.addr = ((state_q == ST_LOAD0) || (state_q == ST_SAVE_LO))
                   ? NV_ADDR_LO : NV_ADDR_HI;
    assign nv.wdata = (state_q == ST_SAVE_LO) ? (lo_q & LO_WR_MASK)
                                              : (hi_q & HI_WR_MASK); // [R19]

    // sequencer: power-on load, saving, busy timing, suspend
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_q <= ST_LOAD0;
            lo_q <= LO_RESET; // [R22]
            hi_q <= HI_RESET; // [R1] [R22]
            tmr_q <= 32'd0;
            op_pe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_LOAD0: state_q <= ST_LOAD1;
                ST_LOAD1: begin
                    lo_q <= nv.rdata & LO_WR_MASK; // [R22]
                    state_q <= ST_LOAD2;
                end
                ST_LOAD2: begin
                    hi_q <= load_hi;
                    state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (wrsr_go) begin
                        lo_q <= new_lo | 8'h01; // [R11]
                        if (nbytes_q >= 3'd3) hi_q <= new_hi;
                        tmr_q <= WRSR_CYCLES;
                        op_pe_q <= 1'b0;
                        state_q <= ST_SAVE_LO;
                    end else if (pe_go) begin
                        lo_q[LO_BUSY] <= 1'b1; // [R11]
                        tmr_q <= OP_CYCLES;
                        op_pe_q <= 1'b1;
                        state_q <= ST_BUSY;
                    end
                end
                ST_SAVE_LO: state_q <= ST_SAVE_HI;
                ST_SAVE_HI: state_q <= ST_BUSY;
                ST_BUSY: begin
                    if (susp_go) begin
                        lo_q[LO_BUSY] <= 1'b0;
                        hi_q[HI_PAUSED] <= 1'b1; // [R1]
                        state_q <= ST_SUSP;
                    end else if (tmr_q <= 32'd1) begin
                        lo_q[LO_BUSY] <= 1'b0; // [R11]
                        lo_q[LO_WEL] <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 32'd1;
                    end
                end
                ST_SUSP: begin
                    if (resume_go) begin
                        lo_q[LO_BUSY] <= 1'b1;
                        hi_q[HI_PAUSED] <= 1'b0; // [R1]
                        state_q <= ST_BUSY;
                    end
                end
            endcase
            if (wren_go) begin
                lo_q[LO_WEL] <= 1'b1; // [R12]
            end else if (wrdi_go) begin
                lo_q[LO_WEL] <= 1'b0;
            end
        end
    end

    // deep power-down and pulse outputs
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            dpd_q <= 1'b0;
            O_CMD_REJECT <= 1'b0;
            O_QUAD_READ <= 1'b0;
        end else begin
            dpd_q <= dpd_go ? 1'b1 : (rel_go ? 1'b0 : dpd_q); // [R18]
            O_CMD_REJECT <= reject;
            O_QUAD_READ <= quad_go; // [R20]
        end
    end

    // status read-out: load at each byte boundary, shift on falling clock
    wire rd_lo = !dpd_q && (cur_opc == OPC_RDSR_LO);
    wire rd_hi = !dpd_q && (cur_opc == OPC_RDSR_HI);
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sh_out_q <= 8'h00;
            rd_act_q <= 1'b0;
            O_SO <= 1'b0;
            O_SO_OE <= 1'b0;
        end else begin
            if (cs_fall) begin
                rd_act_q <= 1'b0;
            end else if (byte_done && (rd_lo || rd_hi)) begin
                sh_out_q <= rd_lo ? lo_q : hi_q;
                rd_act_q <= 1'b1;
            end else if (fall) begin
                O_SO <= sh_out_q[7];
                sh_out_q <= {sh_out_q[6:0], 1'b0};
            end
            O_SO_OE <= rd_act_q && clk_ok && !cs_fall; // no stale drive
        end
    end

    assign O_STATUS_LO = lo_q;
    assign O_STATUS_HI = hi_q;
    assign O_QUAD_LANES = hi_q[HI_QUAD];
    assign O_DEEP_PD = dpd_q;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_NRST);

    guard_open_a: assert property ( // [R6]
        (guard == 2'b00 && write_permit_latch && idle && ex && opc_q == OPC_WRSR
         && nbytes_q >= 3'd2) |=> (state_q == ST_SAVE_LO) && lo_q[LO_BUSY])
        else $error("open status write was not taken");
    wp_lock_a: assert property ( // [R7]
        (guard == 2'b01 && !wp_high && ex && opc_q == OPC_WRSR)
        |=> state_q != ST_SAVE_LO ##0 O_CMD_REJECT)
        else $error("write taken with guard pin low");
    wp_open_a: assert property ( // [R8]
        (guard == 2'b01 && wp_high && write_permit_latch && idle && ex
         && opc_q == OPC_WRSR && nbytes_q >= 3'd2) |=> state_q == ST_SAVE_LO)
        else $error("write refused with guard pin high");
    supply_lock_a: assert property ( // [R9]
        (guard == 2'b10 && cs_rise && opc_q == OPC_WRSR)
        |=> !nv.we ##1 !nv.we)
        else $error("write taken in supply lock-down");
    otp_lock_a: assert property ( // [R10]
        (guard == 2'b11 && idle) |=> $stable(guard) || !I_NRST)
        else $error("one-time guard bits changed");
    busy_flag_a: assert property ( // [R11]
        (state_q == ST_SAVE_LO) |-> lo_q[LO_BUSY] ##1 lo_q[LO_BUSY]
        ##1 lo_q[LO_BUSY])
        else $error("busy low during status write");
    no_permit_a: assert property ( // [R12]
        (!write_permit_latch && ex && is_pe && idle) |=> state_q == ST_IDLE)
        else $error("program or erase taken without permit");
    suspend_a: assert property ( // [R1]
        susp_go |=> hi_q[HI_PAUSED] && !lo_q[LO_BUSY]
        && state_q == ST_SUSP)
        else $error("suspend did not raise paused flag");
    partial_a: assert property ( // [R21]
        (cs_rise && bit_cnt_q != 3'd0 && is_wr) |=> O_CMD_REJECT)
        else $error("partial byte not refused");
    quad_gate_a: assert property ( // [R20]
        O_QUAD_READ |-> $past(hi_q[HI_QUAD]))
        else $error("quad read without four-lane enable");
    deep_pd_a: assert property ( // [R18]
        (dpd_q && cs_rise && opc_q != OPC_RELEASE) |=> dpd_q
        && $stable(lo_q))
        else $error("instruction obeyed in deep power-down");
endmodule : fsw_status_protect

//--- tb/fsw_spi_host.sv
// fsw_spi_host: serial host model driving the flash status block
// assumes: reference clock paces the link, 16 cycles per serial period
`timescale 1ns/1ps
module fsw_spi_host (
    input wire logic i_clk,
    input wire logic i_so,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si
);
    // idle link: clock still low, select high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // one frame msb first, select raised after exactly n bits
    task automatic xfer(input logic [31:0] d, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        @(posedge i_clk) #1;
        o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_si = d[31-i];
            repeat (8) @(posedge i_clk) #1;
            o_sclk = 1'b1;
            rd = {rd[6:0], i_so};
            repeat (8) @(posedge i_clk) #1;
            o_sclk = 1'b0;
        end
        repeat (8) @(posedge i_clk) #1;
        o_cs_n = 1'b1;
        o_si = ~o_si; // released data line shows no stale value
    endtask : xfer
endmodule : fsw_spi_host

//--- tb/test_flash_status_write_protect.sv
// test_flash_status_write_protect: self-checking bench of the status block
// assumes: host model drives the link, hold pin inactive except during the four-lane read
`timescale 1ns/1ps
module test_flash_status_write_protect;
    logic clk = 1'b0, nrst = 1'b0, fnrst = 1'b0, wp_n = 1'b1;
    logic hold_n = 1'b1, clr = 1'b0, se = 1'b0;
    logic sclk, cs_n, si, so, soe, ql, qr, rej, dpd;
    logic sr = 1'b0, sb = 1'b0, sq = 1'b0;
    logic [7:0] lo, hi, rd;
    logic [31:0] lf = 32'h4c529616;
    logic [27:0] nq[$];
    int failures = 0, compares = 0, cyc = 0;
    event chk;

    always #5 clk = ~clk;

    fsw_status_protect #(.OP_CYCLES(400), .WRSR_CYCLES(4)) DUT (
        .I_REF_CLK(clk), .I_NRST(nrst), .I_FACTORY_NRST(fnrst),
        .I_SCLK(sclk), .I_CS_N(cs_n), .I_SI(si), .I_WP_N(wp_n),
        .I_HOLD_N(hold_n), .O_SO(so), .O_SO_OE(soe), .O_STATUS_LO(lo),
        .O_STATUS_HI(hi), .O_QUAD_LANES(ql), .O_QUAD_READ(qr),
        .O_CMD_REJECT(rej), .O_DEEP_PD(dpd));
    fsw_spi_host host (.i_clk(clk), .i_so(so), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_si(si));

    // sticky record of reject, busy, quad and drive pulses in a frame
    always @(posedge clk)
        if (clr)
            {sr, sb, sq, se} <= 4'h0;
        else
            {sr, sb, sq, se} <= {sr, sb, sq, se} | {rej === 1'b1,
                lo[0] === 1'b1, qr === 1'b1, soe === 1'b1};

    // timeout ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic cmp(input logic [20:0] g, input logic [20:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp

    // watcher: oldest note against flags and status bytes
    always @(chk) begin : watch
        logic [27:0] n;
        n = nq.pop_front();
        cmp({sr, sb, dpd, sq, ql, lo & n[23:16], hi},
            {n[27:24], n[1], n[15:8] & n[23:16], n[7:0]});
    end

    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx

    task automatic idle();
        int k;
        for (k = 0; k < 1000 && lo[0] !== 1'b0; k++)
            @(posedge clk) #1;
        if (k == 1000)
            failures++;
    endtask : idle

    // frame, then note {reject, busy, deep, quad read, lo, hi}
    task automatic run(input logic [31:0] f, input int n,
                       input logic [3:0] fl, input logic [15:0] st);
        logic [7:0] m;
        m = (f[31:24] == 8'h06 && fl == 4'h0) ? 8'hfe : 8'hfc;
        clr = 1'b1;
        @(posedge clk) #1;
        clr = 1'b0;
        host.xfer(f, n, rd);
        repeat (10) @(posedge clk) #1;
        nq.push_back({fl, m, st});
        -> chk;
        if (f[31:24] != 8'h02)
            idle();
    endtask : run

    task automatic pwr();
        nrst = 1'b0;
        repeat (4) @(posedge clk) #1;
        nrst = 1'b1;
        repeat (8) @(posedge clk) #1;
    endtask : pwr

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        repeat (8) @(posedge clk) #1;
        {nrst, fnrst} = 2'b11;
        repeat (8) @(posedge clk) #1;
        cmp({lo, hi}, 21'h0);
        lf = nx(lf);
        wp_n = lf[0]; // guard pin driven, never tied
        run(32'h017f_0000, 24, 4'h8, 16'h0000);
        run(32'h0600_0000, 8, 4'h0, 16'h0200);
        run(32'h017f_ba00, 24, 4'h4, 16'h7c3a);
        wp_n = 1'b1;
        lf = nx(lf);
        run({8'h05, lf[7:0], 16'h0}, 16, 4'h0, 16'h7c3a);
        cmp(21'(rd), 21'h7c);
        cmp(21'(se), 21'h1);
        hold_n = 1'b0; // pause pin must be ignored in four-lane mode
        run(32'h6b00_0000, 32, 4'h1, 16'h7c3a);
        cmp(21'(se), 21'h0);
        hold_n = 1'b1;
        run(32'h0600_0000, 8, 4'h0, 16'h7e3a);
        run({8'h02, lf[23:0]}, 32, 4'h8, 16'h7c3a);
        run(32'h0600_0000, 8, 4'h0, 16'h7e3a);
        run(32'h0180_0000, 24, 4'h4, 16'h8038);
        wp_n = 1'b0;
        run(32'h0600_0000, 8, 4'h0, 16'h8238);
        run(32'h0100_0000, 24, 4'h8, 16'h8038);
        wp_n = 1'b1;
        run(32'h6b00_0000, 32, 4'h8, 16'h8038);
        run(32'h0600_0000, 8, 4'h0, 16'h8238);
        run(32'h0100_0100, 24, 4'h4, 16'h0039);
        run(32'h0600_0000, 8, 4'h0, 16'h0239);
        run(32'h0100_0000, 24, 4'h8, 16'h0039);
        pwr();
        cmp({lo, hi}, 21'h0038);
        run(32'h0600_0000, 8, 4'h0, 16'h0238);
        run({8'h02, lf[31:8]}, 32, 4'h4, 16'h0038);
        run(32'h7500_0000, 8, 4'h4, 16'h00b8);
        run(32'h7a00_0000, 8, 4'h4, 16'h0038);
        run(32'h0600_0000, 8, 4'h0, 16'h0238);
        run(32'hb900_0000, 8, 4'h2, 16'h0038);
        run(32'h0600_0000, 8, 4'ha, 16'h0038);
        run(32'hab00_0000, 8, 4'h0, 16'h0038);
        run(32'h0600_0000, 8, 4'h0, 16'h0238);
        run(32'h0100_0000, 11, 4'h8, 16'h0038);
        run(32'h0600_0000, 8, 4'h0, 16'h0238);
        run(32'h0180_0100, 24, 4'h4, 16'h8039);
        run(32'h0600_0000, 8, 4'h0, 16'h8239);
        run(32'h0100_0000, 24, 4'h8, 16'h8039);
        pwr();
        cmp({lo, hi}, 21'h8039);
        wrap_up();
    end
endmodule : test_flash_status_write_protect
